// *** design/mgmt_serial_pkg.sv ***
// package: constants and carrier types for the serial management port
package mgmt_serial_pkg;
    // register addresses
    localparam logic [7:0] power_state_select_addr = 8'h06;
    localparam logic [7:0] ident_word_high_addr = 8'h20;
    localparam logic [7:0] ident_word_low_addr = 8'h21;
    localparam logic [7:0] spec_edition_addr = 8'h22;
    // reset value and ready value of the power state register
    localparam logic [7:0] power_state_select_reset = 8'h01;
    localparam logic [7:0] power_state_ready = 8'h00;
    // identity word field positions
    localparam int product_code_lsb = 11;
    localparam int product_version_lsb = 8;
    localparam int vendor_code_lsb = 0;
    // field widths of the serial frame and the wait limit
    localparam int addr_bits = 8;
    localparam int data_bits = 8;
    localparam logic [4:0] max_wait_cycles = 5'h1F;
    // transmit frame: value and enable of the shared line
    typedef struct packed {
        logic level;
        logic drive;
    } line_out_type;
    // decoded request from the receiver
    typedef struct packed {
        logic is_read;
        logic [7:0] addr;
        logic [7:0] data;
    } request_type;
endpackage

// *** design/mgmt_reg_file.sv ***
// register file behind the serial management port
`timescale 1ns/10ps
`default_nettype none
module mgmt_reg_file #(
    parameter logic [4:0] product_code = 5'h05,    // arbitrary value
    parameter logic [2:0] product_version = 3'h1,  // arbitrary value
    parameter logic [7:0] vendor_code = 8'h5A,     // arbitrary value
    parameter logic [3:0] edition_major = 4'h1,
    parameter logic [3:0] edition_minor = 4'h0
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic write_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic [7:0] power_state_o,
    output logic ready_state_o
);
    logic [15:0] device_ident_word;
    logic [7:0] spec_edition_code;
    logic [7:0] power_state_select;

    // identity word fields
    assign device_ident_word = {product_code, product_version, vendor_code};
    assign spec_edition_code = {edition_major, edition_minor};

    // writable power state register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            power_state_select <= mgmt_serial_pkg::power_state_select_reset;
        end else if (write_i && addr_i == mgmt_serial_pkg::power_state_select_addr) begin
            power_state_select <= wdata_i;
        end
    end

    assign power_state_o = power_state_select;
    assign ready_state_o = (power_state_select == mgmt_serial_pkg::power_state_ready);

    // read mux; unmapped addresses read zero
    always_comb begin
        unique case (addr_i)
            mgmt_serial_pkg::power_state_select_addr: rdata_o = power_state_select;
            mgmt_serial_pkg::ident_word_high_addr: rdata_o = device_ident_word[15:8];
            mgmt_serial_pkg::ident_word_low_addr: rdata_o = device_ident_word[7:0];
            mgmt_serial_pkg::spec_edition_addr: rdata_o = spec_edition_code;
            default: rdata_o = 8'h00;
        endcase
    end
endmodule
`default_nettype wire

// *** design/phy_mgmt_serial_port.sv ***
// device end of the single-wire serial management port
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_serial_port #(
    parameter logic [4:0] wait_cycles = 5'h03
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic serial_data_i,
    output logic serial_data_o,
    output logic serial_data_oe_o,
    output logic [7:0] power_state_o,
    output logic ready_state_o
);
    typedef enum logic [3:0] {
        st_idle = 4'b0000,
        st_op = 4'b0001,
        st_addr = 4'b0010,
        st_wdata = 4'b0011,
        st_wend = 4'b0100,
        st_rend = 4'b0101,
        st_wait = 4'b0111,
        st_start = 4'b1000,
        st_data = 4'b1001,
        st_term = 4'b1010
    } state_type; // codes not listed are illegal and fall back to idle

    // a five-bit parameter cannot pass the limit today; kept so a wider one is caught
    if (wait_cycles > mgmt_serial_pkg::max_wait_cycles) begin : g_wait_limit
        $error("wait_cycles above limit");
    end

    state_type state;
    state_type next_state;
    logic [3:0] bit_count;
    logic [4:0] wait_count;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    mgmt_serial_pkg::request_type req;
    mgmt_serial_pkg::line_out_type line;
    logic line_meta;
    logic line_sync;
    logic reg_write;
    logic [7:0] reg_rdata;
    logic field_done;
    logic data_done;
    logic [1:0] echo_mask;

    // true in every state in which the device owns the shared line
    function automatic logic owns_line(input state_type s);
        owns_line = (s == st_wait) || (s == st_start) || (s == st_data) || (s == st_term);
    endfunction

    // true on the last bit of a field that is width bits long
    function automatic logic last_bit(input logic [3:0] count, input int width);
        last_bit = (count == 4'(width - 1));
    endfunction

    // two-stage synchroniser on the pin; adds two cycles of latency the mac must allow for
    // both stages reset to zero, the level at which the idle line rests
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            line_meta <= 1'b0;
            line_sync <= 1'b0;
        end else begin
            line_meta <= serial_data_i;
            line_sync <= line_meta;
        end
    end

    // field ends; address and data are both eight bits today but are counted apart
    assign field_done = last_bit(bit_count, mgmt_serial_pkg::addr_bits);
    assign data_done = last_bit(bit_count, mgmt_serial_pkg::data_bits);

    // the device hears its own reply through the synchroniser two cycles late;
    // without this mask a last data bit of one would be taken for a start bit
    // and the device would swallow the mac's next frame
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            echo_mask <= 2'b00;
        end else begin
            echo_mask <= {echo_mask[0], owns_line(state)};
        end
    end

    // frame sequencing; the idle-low line means a one in st_idle is a start bit unless echo_mask[1] is set
    // read turnaround, in pin cycles with the mac's start bit at 0: the closing zero
    // stands on the pin in cycle 10 and reaches line_sync in cycle 12 (st_rend);
    // the mac lets go at the start of cycle 11, so the first wait zero, or the start
    // bit when wait_cycles is 0, is driven from cycle 13, the second clock after release
    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: if (line_sync && !echo_mask[1]) next_state = st_op;
            st_op: next_state = st_addr;
            st_addr: if (field_done) next_state = req.is_read ? st_rend : st_wdata;
            st_wdata: if (data_done) next_state = st_wend;
            st_wend: next_state = st_idle;
            st_rend: next_state = (wait_cycles == 5'h00) ? st_start : st_wait;
            st_wait: if (wait_count == wait_cycles - 5'h01) next_state = st_start;
            st_start: next_state = st_data;
            st_data: if (data_done) next_state = st_term;
            st_term: next_state = st_idle;
            default: next_state = st_idle;
        endcase
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // bit and wait counters; bit_count restarts on every state change
    // wait_count runs only in st_wait, so every reply waits exactly wait_cycles
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bit_count <= 4'h0;
            wait_count <= 5'h00;
        end else begin
            bit_count <= (state == next_state) ? bit_count + 4'h1 : 4'h0;
            wait_count <= (state == st_wait) ? wait_count + 5'h01 : 5'h00;
        end
    end

    // capture op flag, address and write data, msb first
    // req holds address and data until the next frame, so the read mux stays
    // steady through the whole reply
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            req <= '0;
            shift_in <= 8'h00;
        end else begin
            if (state == st_op) begin
                req.is_read <= line_sync;
            end
            if (state == st_addr || state == st_wdata) begin
                shift_in <= {shift_in[6:0], line_sync};
            end
            if (state == st_addr && field_done) begin
                req.addr <= {shift_in[6:0], line_sync};
            end
            if (state == st_wdata && data_done) begin
                req.data <= {shift_in[6:0], line_sync};
            end
        end
    end

    // commit the write one cycle after the last data bit
    assign reg_write = (state == st_wend);

    // read data loaded at start bit, shifted msb first
    // loaded on the edge that launches bit 7, so bit 6 is next at position 6
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            shift_out <= 8'h00;
        end else if (state == st_start) begin
            shift_out <= reg_rdata;
        end else if (state == st_data) begin
            shift_out <= {shift_out[6:0], 1'b0};
        end
    end

    // line drive registered so each bit is launched on the rising edge
    // bit 7 comes straight from the mux because shift_out loads on that same edge
    always_comb begin
        line.drive = owns_line(next_state);
        line.level = 1'b0;
        if (next_state == st_start) begin
            line.level = 1'b1;
        end else if (next_state == st_data) begin
            line.level = (state == st_start) ? reg_rdata[7] : shift_out[6];
        end
    end

    // registered pin outputs; computed from next_state, so oe and level line up
    // with the state they belong to and carry no glitches onto the shared wire
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            serial_data_o <= 1'b0;
            serial_data_oe_o <= 1'b0;
        end else begin
            serial_data_o <= line.level;
            serial_data_oe_o <= line.drive;
        end
    end

    // register file; writes commit one cycle after the last data bit is seen
    mgmt_reg_file u_regs (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .write_i(reg_write),
        .addr_i(req.addr),
        .wdata_i(req.data),
        .rdata_o(reg_rdata),
        .power_state_o(power_state_o),
        .ready_state_o(ready_state_o)
    );
endmodule
`default_nettype wire

// *** bench/mgmt_serial_asserts.sv ***
// checker for the serial management port
`timescale 1ns/10ps
`default_nettype none
module mgmt_serial_asserts #(
    parameter logic [4:0] wait_cycles = 5'h03
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic serial_data_i,
    input wire logic serial_data_o,
    input wire logic serial_data_oe_o,
    input wire logic [7:0] power_state_o,
    input wire logic ready_state_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic [5:0] held;
    // cycles the device has held the line so far
    always_ff @(posedge clk_i) begin
        held <= (serial_data_oe_o && !reset_i) ? held + 6'h01 : 6'h00;
    end
    // read frame seen at the pin, ending in the zero before the hand-over
    sequence read_frame;
        $past(serial_data_i, 13) && $past(serial_data_i, 12) && !$past(serial_data_i, 3);
    endsequence
    sequence reply_end;
        !serial_data_o ##1 !serial_data_oe_o;
    endsequence
    a_ready_from_power: assert property (ready_state_o == (power_state_o == 8'h00))
        else $error("ready flag wrong");
    a_reset_idle_state: assert property (disable iff (1'b0) $fell(reset_i) |-> !serial_data_oe_o && power_state_o == 8'h01)
        else $error("reset state wrong");
    a_wait_bits_zero: assert property (serial_data_oe_o && held < wait_cycles |-> !serial_data_o)
        else $error("wait bit not zero");
    a_start_bit_one: assert property (serial_data_oe_o && held == wait_cycles |-> serial_data_o ##1 serial_data_oe_o)
        else $error("start bit missing");
    a_reply_ends_zero: assert property (serial_data_oe_o && held == wait_cycles + 9 |-> reply_end)
        else $error("reply end wrong");
    a_reply_length: assert property (serial_data_oe_o |-> held <= wait_cycles + 9)
        else $error("reply too long");
    a_reply_needs_read: assert property ($rose(serial_data_oe_o) |-> read_frame)
        else $error("reply without read");
    a_write_stores_data: assert property ($changed(power_state_o) |-> $past(serial_data_i, 21)
        && !$past(serial_data_i, 20) && power_state_o[7] == $past(serial_data_i, 11)
        && power_state_o[0] == $past(serial_data_i, 4))
        else $error("register change without write");
endmodule
bind phy_mgmt_serial_port mgmt_serial_asserts #(.wait_cycles(wait_cycles)) mgmt_serial_asserts_inst (
    .clk_i(clk_i), .reset_i(reset_i), .serial_data_i(serial_data_i), .serial_data_o(serial_data_o),
    .serial_data_oe_o(serial_data_oe_o), .power_state_o(power_state_o), .ready_state_o(ready_state_o));
`default_nettype wire

// *** bench/mac_model.sv ***
// behavioural controller at the far end of the management line
`timescale 1ns/10ps
`default_nettype none
module mac_model (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o,
    output logic drive_o
);
    // held at zero at start; a read takes the line back, a write leaves it released
    initial begin
        line_o = 1'b0;
        drive_o = 1'b1;
    end
    // read: flag, address msb first, zero, release, hunt bounded
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output int idle);
        logic [10:0] frame;
        frame = {2'b11, addr, 1'b0};
        for (int i = 10; i >= 0; i--) begin
            @(posedge clk_i);
            drive_o <= 1'b1;
            line_o <= frame[i];
        end
        @(posedge clk_i);
        drive_o <= 1'b0;
        idle = 0;
        while (idle < 40) begin
            @(posedge clk_i);
            if (line_i === 1'b1) break;
            idle++;
        end
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_i);
            data[i] = line_i;
        end
        @(posedge clk_i);
        drive_o <= 1'b1; // take the line back once released
    endtask
    // write: whole frame driven here, then let go
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        logic [18:0] frame;
        frame = {2'b10, addr, data, 1'b0};
        for (int i = 18; i >= 0; i--) begin
            @(posedge clk_i);
            drive_o <= 1'b1;
            line_o <= frame[i];
        end
        @(posedge clk_i);
        drive_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** bench/phy_mgmt_serial_port_tb.sv ***
// testbench for the serial management port
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_serial_port_tb;
    localparam logic [4:0] wait_cycles = 5'h03;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic dev_data, dev_oe, ready, mac_line, mac_drive, line;
    logic [7:0] power;
    int fail_count = 0;
    int checks = 0;
    // released line rests at zero
    assign line = dev_oe ? dev_data : (mac_drive ? mac_line : 1'b0);
    always #25 clk = ~clk;
    phy_mgmt_serial_port #(.wait_cycles(wait_cycles)) phy_mgmt_serial_port_inst (.clk_i(clk), .reset_i(reset),
        .serial_data_i(line), .serial_data_o(dev_data), .serial_data_oe_o(dev_oe), .power_state_o(power),
        .ready_state_o(ready));
    mac_model mac_model_inst (.clk_i(clk), .line_i(line), .line_o(mac_line), .drive_o(mac_drive));
    task automatic check(input string what, input logic [7:0] expected, input logic [7:0] seen);
        checks++;
        if (seen !== expected) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, expected, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // a hung reply counts as a mismatch and ends the run
    task automatic read_check(input string what, input logic [7:0] addr, input logic [7:0] expected);
        logic [7:0] data;
        int idle;
        mac_model_inst.read_reg(addr, data, idle);
        check("wait", 8'(wait_cycles) + 8'h02, 8'(idle));
        if (idle >= 40) stop_test();
        check(what, expected, data);
    endtask
    task automatic ident_reads;
        read_check("ident high", mgmt_serial_pkg::ident_word_high_addr, {5'h05, 3'h1});
        read_check("ident low", mgmt_serial_pkg::ident_word_low_addr, 8'h5A);
        read_check("edition", mgmt_serial_pkg::spec_edition_addr, {4'h1, 4'h0});
        read_check("unmapped", 8'h7F, 8'h00);
    endtask
    // writes straight after reads, then a read-only target
    task automatic power_writes;
        read_check("power", 8'h06, 8'h01);
        mac_model_inst.write_reg(8'h06, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        check("ready", 8'h01, {7'h00, ready});
        mac_model_inst.write_reg(8'h06, 8'hA5);
        repeat (2) @(posedge clk);
        #1;
        check("power", 8'hA5, power);
        read_check("power back", 8'h06, 8'hA5);
        mac_model_inst.write_reg(8'h20, 8'h00);
        read_check("ident kept", 8'h20, {5'h05, 3'h1});
    endtask
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        check("reset power", 8'h01, power);
        ident_reads();
        power_writes();
        stop_test();
    end
endmodule
`default_nettype wire
